// ===== wwrs_pkg.sv
// package: constants and types for the wake/watchdog/reset supervisor
package wwrs_pkg;
  // timing coefficients, applied to one delay-capacitor unit (0.1 uF -> 40 ms wake period)
  localparam int WAKE_COEF = 400000;
  localparam int RDLY_COEF = 50000;
  localparam int RWAKE_COEF = 200000;
  // clock rate and the clock period in ns
  localparam int CLOCK_MHZ = 50;
  localparam int CLOCK_PERIOD_NS = 20;
  // default prescale: clock cycles per coefficient unit (0.1 uF -> 100 ns per unit -> 5 cycles)
  localparam int UNIT_NS = 100;
  localparam int UNIT_CYCLES = (UNIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // wake half period and delay counts, all in prescaled ticks
  localparam logic [19:0] WAKE_HALF = 20'(WAKE_COEF / 2);
  localparam logic [19:0] RDLY_TICKS = 20'(RDLY_COEF);
  localparam logic [19:0] RWAKE_TICKS = 20'(RWAKE_COEF);
  localparam logic [19:0] CNT_ZERO = 20'h00000;
  localparam logic [19:0] CNT_ONE = 20'h00001;
  localparam int PRE_W = 16;
  // supervisor phases
  typedef enum logic [1:0] {
    WWRS_RESET = 2'b00,
    WWRS_DELAY = 2'b01,
    WWRS_HIGH = 2'b10,
    WWRS_LOW = 2'b11
  } wwrs_state_t;
  // outputs toward the microprocessor
  typedef struct packed {
    logic wake;
    logic reset_n;
  } wwrs_out_t;
endpackage : wwrs_pkg

// ===== wwrs_supervisor.sv
// module: wake-up generator, watchdog and reset supervisor
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - wake output is a continuous square wave, equal halves, period from timing constant.
// - first watchdog falling edge in a cycle drops wake until next cycle.
// - later watchdog falling edges in the same cycle are ignored.
// - no watchdog edge in a whole cycle gives a reset pulse at its end.
// - wake is forced low while reset is asserted.
// - after reset release the wake cycle restarts after the reset-to-wake delay.
// - at power-up reset holds until the output is reported in regulation.
// - reset asserts while output is reported under voltage, until restored.
// - reset stays asserted one reset-delay interval after its cause clears.
// - wake period, reset delay, reset-to-wake delay scale 8:1:4 from one constant.
module wwrs_supervisor
  import wwrs_pkg::*;
(
  // clock and power-on reset
  input wire logic clock,
  input wire logic rstn,
  // timing constant: clock cycles per coefficient unit
  input wire logic [PRE_W-1:0] unit_cycles,
  // regulator status, high while output is within regulation
  input wire logic in_regulation,
  // watchdog from the microprocessor
  input wire logic watchdog_input,
  // outputs toward the microprocessor
  output wwrs_out_t sup_out
);

  // ***************************************
  // input conditioning
  // ***************************************
  logic [2:0] wd_sync;
  logic [2:0] reg_sync;
  logic wd_level;
  logic reg_ok;
  logic wd_fall;

  // three-stage synchronisers; level changes once stages two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wd_sync <= 3'h7;
      reg_sync <= 3'h0;
    end else begin
      wd_sync <= {wd_sync[1:0], watchdog_input};
      reg_sync <= {reg_sync[1:0], in_regulation};
    end
  end

  // filtered levels and falling edge of watchdog
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wd_level <= 1'b1;
      reg_ok <= 1'b0;
    end else begin
      if (wd_sync[1] == wd_sync[2]) begin
        wd_level <= wd_sync[2];
      end
      if (reg_sync[1] == reg_sync[2]) begin
        reg_ok <= reg_sync[2];
      end
    end
  end

  assign wd_fall = wd_level && (wd_sync[1] == wd_sync[2]) && !wd_sync[2];

  // ***************************************
  // prescaler
  // ***************************************
  logic [PRE_W-1:0] pre_cnt;
  logic tick;

  // one tick per timing unit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= '0;
      tick <= 1'b0;
    end else if (pre_cnt + PRE_W'(1) >= unit_cycles) begin
      pre_cnt <= '0;
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + PRE_W'(1);
      tick <= 1'b0;
    end
  end

  // ***************************************
  // supervisor sequence
  // ***************************************
  wwrs_state_t state;
  logic [19:0] cnt;
  logic wd_seen;
  logic wake_low;
  logic wd_miss;

  // end of a complete wake cycle: last tick of the low half
  function automatic logic cycle_end(input wwrs_state_t s, input logic t, input logic [19:0] c);
    return (s == WWRS_LOW) && t && (c == CNT_ONE);
  endfunction

  // missed watchdog at end of a complete wake cycle
  assign wd_miss = cycle_end(state, tick, cnt) && !wd_seen;

  // phase and interval counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= WWRS_RESET;
      cnt <= RDLY_TICKS;
    end else if (!reg_ok || wd_miss) begin
      state <= WWRS_RESET;
      cnt <= RDLY_TICKS;
    end else begin
      unique case (state)
        WWRS_RESET: begin
          if (tick) begin
            if (cnt == CNT_ONE) begin
              state <= WWRS_DELAY;
              cnt <= RWAKE_TICKS;
            end else begin
              cnt <= cnt - CNT_ONE;
            end
          end
        end
        WWRS_DELAY: begin
          if (tick) begin
            if (cnt == CNT_ONE) begin
              state <= WWRS_HIGH;
              cnt <= WAKE_HALF;
            end else begin
              cnt <= cnt - CNT_ONE;
            end
          end
        end
        WWRS_HIGH: begin
          if (tick) begin
            if (cnt == CNT_ONE) begin
              state <= WWRS_LOW;
              cnt <= WAKE_HALF;
            end else begin
              cnt <= cnt - CNT_ONE;
            end
          end
        end
        WWRS_LOW: begin
          if (tick) begin
            if (cnt == CNT_ONE) begin
              state <= WWRS_HIGH;
              cnt <= WAKE_HALF;
            end else begin
              cnt <= cnt - CNT_ONE;
            end
          end
        end
      endcase
    end
  end

  // watchdog edge capture, one per wake cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wd_seen <= 1'b0;
      wake_low <= 1'b0;
    end else if (state == WWRS_RESET || state == WWRS_DELAY) begin
      wd_seen <= 1'b0;
      wake_low <= 1'b0;
    end else if (cycle_end(state, tick, cnt)) begin
      wd_seen <= 1'b0; // new cycle starts
      wake_low <= 1'b0;
    end else if (wd_fall && !wd_seen) begin
      wd_seen <= 1'b1;
      wake_low <= 1'b1;
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sup_out <= '0;
    end else begin
      sup_out.reset_n <= (state != WWRS_RESET) && reg_ok && !wd_miss;
      sup_out.wake <= (state == WWRS_HIGH) && !(wd_fall && !wd_seen) && !wake_low && reg_ok;
    end
  end

  // ***************************************
  // assertion helpers
  // ***************************************
  logic [19:0] high_ticks;

  // ticks seen while wake stands high, cleared when it drops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      high_ticks <= CNT_ZERO;
    end else if (!sup_out.wake) begin
      high_ticks <= CNT_ZERO;
    end else if (tick) begin
      high_ticks <= high_ticks + CNT_ONE;
    end
  end

  // ***************************************
  // assertions
  // ***************************************
  sequence reset_shown;
    !sup_out.reset_n;
  endsequence

  wake_in_reset_a: assert property (@(posedge clock) disable iff (!rstn)
    reset_shown |-> !sup_out.wake) else $error("wake high during reset");

  reg_loss_a: assert property (@(posedge clock) disable iff (!rstn)
    !reg_ok |=> !sup_out.reset_n) else $error("reset not asserted on under voltage");

  miss_reset_a: assert property (@(posedge clock) disable iff (!rstn)
    wd_miss |=> !sup_out.reset_n) else $error("missed watchdog gave no reset");

  wd_drop_a: assert property (@(posedge clock) disable iff (!rstn)
    (wd_fall && !wd_seen && state == WWRS_HIGH && reg_ok) |=> !sup_out.wake [*2])
    else $error("wake not dropped after watchdog edge");

  wd_ignore_a: assert property (@(posedge clock) disable iff (!rstn)
    (wd_seen && wd_fall && state != WWRS_RESET) |=> wd_seen) else $error("second edge changed capture");

  release_delay_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == WWRS_DELAY) |=> !sup_out.wake) else $error("wake before reset-to-wake delay");

  power_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == WWRS_RESET && $past(state) == WWRS_RESET) |-> !sup_out.reset_n)
    else $error("reset released too early");

  rdly_load_a: assert property (@(posedge clock) disable iff (!rstn)
    ($rose(state == WWRS_DELAY)) |-> $past(cnt) == CNT_ONE) else $error("reset delay cut short");

  half_load_a: assert property (@(posedge clock) disable iff (!rstn)
    ($rose(state == WWRS_HIGH)) |-> cnt == WAKE_HALF) else $error("wake half period wrong");

  sequence cycle_end_s;
    state == WWRS_LOW && tick && cnt == CNT_ONE;
  endsequence

  sequence wake_shown;
    sup_out.wake;
  endsequence

  // a finished cycle starts a new high half or a reset
  cycle_restart_a: assert property (@(posedge clock) disable iff (!rstn)
    cycle_end_s |=> (state == WWRS_HIGH || state == WWRS_RESET)) else $error("cycle did not restart");

  // wake never stands high longer than one half period
  high_span_a: assert property (@(posedge clock) disable iff (!rstn)
    high_ticks <= WAKE_HALF) else $error("wake high half too long");

  // low half is loaded with the same count as the high half
  low_load_a: assert property (@(posedge clock) disable iff (!rstn)
    ($rose(state == WWRS_LOW)) |-> cnt == WAKE_HALF) else $error("wake low half wrong");

  // wake only follows a high phase
  wake_source_a: assert property (@(posedge clock) disable iff (!rstn)
    wake_shown |-> $past(state) == WWRS_HIGH) else $error("wake high outside high phase");

  // under voltage pulls wake low at once
  uv_wake_a: assert property (@(posedge clock) disable iff (!rstn)
    !reg_ok |=> !sup_out.wake) else $error("wake high under voltage");

  // once an edge is captured wake stays low for the cycle
  seen_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    wd_seen |=> !sup_out.wake) else $error("wake rose after captured edge");

  // a missed watchdog reloads the reset delay
  miss_load_a: assert property (@(posedge clock) disable iff (!rstn)
    wd_miss |=> (state == WWRS_RESET && cnt == RDLY_TICKS)) else $error("miss did not reload delay");

  // release delay starts from the full reset-to-wake count
  delay_load_a: assert property (@(posedge clock) disable iff (!rstn)
    ($rose(state == WWRS_DELAY)) |-> cnt == RWAKE_TICKS) else $error("reset to wake delay wrong");

  // reset output rises only into the release delay
  release_phase_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(sup_out.reset_n) |-> state == WWRS_DELAY) else $error("reset released outside delay");

  // interval counter never runs down to zero
  cnt_live_a: assert property (@(posedge clock) disable iff (!rstn)
    cnt != CNT_ZERO) else $error("interval counter reached zero");

  // loss of regulation restarts the reset delay
  reg_restart_a: assert property (@(posedge clock) disable iff (!rstn)
    !reg_ok |=> (state == WWRS_RESET && cnt == RDLY_TICKS)) else $error("under voltage kept old count");

  // reset holds until its delay has run out
  reset_count_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == WWRS_RESET && !(tick && cnt == CNT_ONE)) |=> state == WWRS_RESET)
    else $error("reset left before delay end");

  // a recognised falling edge settles the filtered level low
  edge_settle_a: assert property (@(posedge clock) disable iff (!rstn)
    wd_fall |=> !wd_level) else $error("watchdog level not settled");

  // with a slow prescale a tick is one clock wide
  tick_gap_a: assert property (@(posedge clock) disable iff (!rstn)
    (tick && unit_cycles > 16'h0001) |=> !tick) else $error("tick wider than one clock");

endmodule : wwrs_supervisor
`default_nettype wire

// ===== wwrs_cpu_model.sv
// processor model that answers wake rises with watchdog pulses
`timescale 1ns/100ps
`default_nettype none
module wwrs_cpu_model (
  // clock
  input wire logic clock,
  // from the supervisor
  input wire logic wake,
  // bench control: stay asleep, no pulse
  input wire logic quiet,
  // toward the supervisor
  output logic watchdog_input
);
  logic wake_q = 1'h0;
  // idle level of the watchdog line is high
  initial watchdog_input = 1'h1;
  // two pulses per wake rise, the second redundant
  always @(posedge clock) begin
    wake_q <= wake;
    if (wake && !wake_q && !quiet) begin
      repeat (2) begin
        repeat (20) @(posedge clock);
        watchdog_input <= 1'h0;
        repeat (20) @(posedge clock);
        watchdog_input <= 1'h1;
      end
    end
  end
endmodule // wwrs_cpu_model
`default_nettype wire

// ===== wwrs_supervisor_bench.sv
// testbench for the wake, watchdog and reset supervisor
`timescale 1ns/100ps
`default_nettype none
module wwrs_supervisor_bench;
  import wwrs_pkg::*;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic in_regulation = 1'h0;
  logic quiet = 1'h0;
  wire logic watchdog_input;
  wwrs_out_t sup_out;
  int fail_count = 0;
  int num_checks = 0;
  time t_reg, t_wr, t_wf, t_rr, t_rf, t_wd, d;
  // clock generation
  initial begin
    forever #10 clock = ~clock;
  end
  wwrs_supervisor u_dut (.clock(clock), .rstn(rstn), .unit_cycles(16'h0001), .in_regulation(in_regulation),
    .watchdog_input(watchdog_input), .sup_out(sup_out));
  wwrs_cpu_model u_cpu (.clock(clock), .wake(sup_out.wake), .quiet(quiet), .watchdog_input(watchdog_input));
  // edge time stamps
  always @(posedge sup_out.wake) t_wr = $time;
  always @(negedge sup_out.wake) t_wf = $time;
  always @(posedge sup_out.reset_n) t_rr = $time;
  always @(negedge sup_out.reset_n) t_rf = $time;
  always @(negedge watchdog_input) if (t_wd < t_wr) t_wd = $time;
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  function automatic bit near(input time a, input time b);
    return (a > b ? a - b : b - a) <= 400;
  endfunction
  // bounded wait for wake (w=1) or reset_n (w=0) to reach v
  task automatic wait_sig(input bit w, input logic v);
    int n;
    n = 0;
    while (((w ? sup_out.wake : sup_out.reset_n) !== v) && n < 3000000) begin
      @(negedge clock);
      n++;
    end
    check(n < 3000000, "signal wait timed out");
  endtask
  task automatic power_up;
    repeat (200) @(posedge clock);
    check(sup_out.reset_n === 1'h0 && sup_out.wake === 1'h0, "reset released out of regulation");
    @(posedge clock) in_regulation <= 1'h1;
    t_reg = $time;
    wait_sig(0, 1'h1);
    d = RDLY_COEF * CLOCK_PERIOD_NS;
    check(near(t_rr - t_reg, d), "reset delay off");
    check(sup_out.wake === 1'h0, "wake high during reset delay");
    wait_sig(1, 1'h1);
    check(near(t_wr - t_rr, 4 * d), "reset to wake delay off");
  endtask
  task automatic served_cycle;
    time t0;
    t0 = t_wr;
    wait_sig(1, 1'h0);
    check(t_wd > t0 && t_wf - t_wd <= 200, "wake slow to follow watchdog");
    @(posedge clock) quiet <= 1'h1;
    wait_sig(1, 1'h1);
    check(near(t_wr - t0, 8 * d), "wake period off");
    check(t_rf < t0 && sup_out.reset_n === 1'h1, "reset on served cycle");
  endtask
  task automatic quiet_cycle;
    time t0;
    t0 = t_wr;
    wait_sig(1, 1'h0);
    check(near(t_wf - t0, 4 * d), "wake high half off");
    wait_sig(0, 1'h0);
    check(near(t_rf - t0, 8 * d), "missing watchdog reset off");
    @(posedge clock) quiet <= 1'h0;
    wait_sig(0, 1'h1);
    check(near(t_rr - t_rf, d) && t_wr == t0, "reset pulse wrong");
    wait_sig(1, 1'h1);
    check(near(t_wr - t_rr, 4 * d), "wake restart off");
  endtask
  task automatic under_voltage;
    @(posedge clock) in_regulation <= 1'h0;
    repeat (10) @(negedge clock);
    check(sup_out.reset_n === 1'h0 && sup_out.wake === 1'h0, "no reset on under voltage");
    repeat (500) @(negedge clock);
    check(sup_out.reset_n === 1'h0, "reset left early");
    @(posedge clock) in_regulation <= 1'h1;
    t_reg = $time;
    wait_sig(0, 1'h1);
    check(near(t_rr - t_reg, d), "recovery delay off");
  endtask
  task automatic stop_test;
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    power_up;
    served_cycle;
    quiet_cycle;
    under_voltage;
    stop_test;
  end
  // watchdog against a hang
  initial begin
    #90000000;
    fail_count++;
    stop_test;
  end
endmodule // wwrs_supervisor_bench
`default_nettype wire
